// ---- bench/gpiomc_pins.sv ----
// far-side pin model: resolves each line from device drive and outside drive
`timescale 1ns/1ps
module gpiomc_pins (
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe_n,
  input  wire logic [7:0] a_ext,
  input  wire logic [7:0] port_b_out,
  input  wire logic [7:0] port_b_oe_n,
  input  wire logic [7:0] b_ext,
  input  wire logic [2:0] port_c_out,
  input  wire logic [2:0] port_c_oe_n,
  input  wire logic [2:0] c_ext,
  output logic      [7:0] port_a_in,
  output logic      [7:0] port_b_in,
  output logic      [2:0] port_c_in
);
  assign port_a_in = (port_a_oe_n & a_ext) | (~port_a_oe_n & port_a_out);
  assign port_b_in = (port_b_oe_n & b_ext) | (~port_b_oe_n & port_b_out);
  assign port_c_in = (port_c_oe_n & c_ext) | (~port_c_oe_n & port_c_out);
endmodule : gpiomc_pins

// ---- bench/tb.sv ----
// self-checking bench for the gpio ports and misc control block
`timescale 1ns/1ps
module tb;
  import gpiomc_pkg::*;
  logic sys_clk, rst, wr_stb, rd_stb, rd_seen, cpu_clk_tick, i2c_enable, i2c_sda_out;
  logic i2c_scl_out, i2c_sda_in, i2c_scl_in, sci_enable, sci_tx_out, sci_rx_in;
  logic usb_tx_active, low_voltage_detect_off, osc_12mhz_select;
  logic [3:0] addr, ext_int_edge_reg, ext_int_in;
  logic [7:0] wdata, rdata, port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out;
  logic [7:0] port_b_oe_n, analog_pin_select, a_ext, b_ext, la, lb, da, db, lc, dc, e;
  logic [2:0] port_c_in, port_c_out, port_c_oe_n, c_ext, analog_channel_select;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int miscompares, cmp_count;
  gpiomc_top i_dut (.sys_clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .port_a_in,
    .port_a_out, .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n, .port_c_in,
    .port_c_out, .port_c_oe_n, .cpu_clk_tick, .i2c_enable, .i2c_sda_out, .i2c_scl_out,
    .i2c_sda_in, .i2c_scl_in, .analog_channel_select, .analog_pin_select,
    .ext_int_edge_reg, .ext_int_in, .sci_enable, .sci_tx_out, .sci_rx_in, .usb_tx_active,
    .low_voltage_detect_off, .osc_12mhz_select);
  gpiomc_pins i_pins (.port_a_out, .port_a_oe_n, .a_ext, .port_b_out, .port_b_oe_n, .b_ext,
    .port_c_out, .port_c_oe_n, .c_ext, .port_a_in, .port_b_in, .port_c_in);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    exp_q.push_back(x);
    @(posedge sys_clk);
  endtask : rd
  // idle the bus, then let pins settle and move to mid-cycle for sampling
  task automatic look(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : look
  always @(posedge sys_clk) rd_seen <= rd_stb;
  // read data stands only in the cycle after the strobe
  always @(negedge sys_clk) if (rd_seen === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
  initial begin
    {rst, seed} = {1'b1, 32'h0000005E};
    {wr_stb, rd_stb, addr, wdata, cpu_clk_tick, i2c_enable, i2c_sda_out} = '0;
    {i2c_scl_out, sci_enable, sci_tx_out, usb_tx_active, ext_int_edge_reg} = '0;
    {analog_channel_select, a_ext, b_ext, c_ext} = {3'h0, 8'hA5, 8'h3C, 3'h5};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_PORT_A_DIR, 8'h00);
    rd(OFS_PORT_B_DIR, 8'h00);
    rd(OFS_PORT_A_DATA, 8'hA5);
    rd(OFS_PORT_B_DATA, 8'h3C);
    rd(OFS_PORT_C_DIR, 8'hF8);
    rd(OFS_PORT_C_DATA, 8'hFD);
    rd(OFS_MISC, 8'hF0);
    rd(4'h6, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {la, lb, da, db, lc, dc} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      a_ext <= rnd();
      c_ext <= la[7:5];
      wr(OFS_PORT_A_DATA, la);
      wr(OFS_PORT_B_DATA, lb);
      wr(OFS_PORT_C_DATA, lc);
      wr(OFS_PORT_A_DIR, da);
      wr(OFS_PORT_B_DIR, db);
      wr(OFS_PORT_C_DIR, dc);
      look(3);
      chk("a_oe_n", ~da | (la & 8'h06), port_a_oe_n);
      chk("b_oe_n", ~db, port_b_oe_n);
      chk("c_oe_n", {5'h00, ~dc[2:0]}, {5'h00, port_c_oe_n});
      chk("b_out", lb, port_b_out);
      chk("a_out", la & 8'hF9, port_a_out & 8'hF9);
      @(posedge sys_clk);
      rd(OFS_PORT_A_DATA, (la & da) | (port_a_in & ~da));
      rd(OFS_PORT_B_DATA, (lb & db) | (b_ext & ~db));
      rd(OFS_PORT_C_DATA, {5'h1F, (lc[2:0] & dc[2:0]) | (la[7:5] & ~dc[2:0])});
      rd(OFS_PORT_C_DIR, dc | 8'hF8);
    end
    wr(OFS_MISC, 8'h0C);
    wr(OFS_MISC, 8'h00);
    rd(OFS_MISC, 8'hFC);
    look(2);
    chk("lvd_off", 8'h01, {7'h00, low_voltage_detect_off});
    chk("osc_sel", 8'h01, {7'h00, osc_12mhz_select});
    @(posedge sys_clk);
    wr(OFS_MISC, 8'h01);
    cpu_clk_tick <= 1'b1;
    look(3);
    e = port_a_out;
    chk("clk_oe_n", 8'h00, {7'h00, port_a_oe_n[0]});
    @(negedge sys_clk);
    chk("clk_out", {7'h00, ~e[0]}, {7'h00, port_a_out[0]});
    @(posedge sys_clk);
    wr(OFS_MISC, 8'h02);
    i2c_enable <= 1'b1;
    sci_enable <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      {usb_tx_active, sci_tx_out, i2c_sda_out, i2c_scl_out} <= {v[0], v[0], v[0], ~v[0]};
      look(3);
      chk("usb_c2", {6'h00, v[0], 1'b0}, {6'h00, port_c_out[2], port_c_oe_n[2]});
      chk("sci_c1", {6'h00, v[0], 1'b0}, {6'h00, port_c_out[1], port_c_oe_n[1]});
      chk("i2c_oe_n", {6'h00, ~v[0], v[0]}, {6'h00, port_a_oe_n[2:1]});
      chk("i2c_in", {6'h00, port_a_in[2:1]}, {6'h00, i2c_scl_in, i2c_sda_in});
      chk("sci_in", {7'h00, port_c_in[0]}, {7'h00, sci_rx_in});
      @(posedge sys_clk);
    end
    for (int s = 0; s < 8; s++) begin
      analog_channel_select <= s[2:0];
      look(2);
      chk("analog_sel", 8'h01 << s, analog_pin_select);
      @(posedge sys_clk);
    end
    wr(OFS_PORT_B_DIR, 8'h00);
    ext_int_edge_reg <= 4'hA;
    b_ext <= 8'hF0;
    look(3);
    chk("ext_int", 8'h0A, {4'h0, ext_int_in});
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_MISC, 8'hF0);
    rd(OFS_PORT_A_DIR, 8'h00);
    look(2);
    close_out();
  end
endmodule : tb

// ---- core/gpiomc_top.sv ----
// gpio ports a, b, c with misc control register and pin muxing
//
// Overview of operation
// RL1: direction bit set makes pin output
// RL2: data read gives latch or pin
// RL3: data writes always update output latch
// RL4: ports a and b reset to zero
// RL5: port c upper bits fixed, read ones
// RL6: a1, a2 open drain, i2c when enabled
// RL7: channel select routes port b pin
// RL8: port b 4-7 feed enabled ext interrupts
// RL9: misc resets F0h, upper nibble reads ones
// RL10: detector disable bit set-only until reset
// RL11: oscillator divider bit set-only until reset
// RL12: usb indicator drives port c line 2
// RL13: clock out enable routes clock to a0
// RL14: alternate functions override normal programming
// RL15: reserved bits ignore writes, read fixed
`timescale 1ns/1ps
module gpiomc_top
  import gpiomc_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [gpiomc_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [7:0]                  rdata,
  input  wire logic [7:0]                  port_a_in,
  output logic      [7:0]                  port_a_out,
  output logic      [7:0]                  port_a_oe_n,
  input  wire logic [7:0]                  port_b_in,
  output logic      [7:0]                  port_b_out,
  output logic      [7:0]                  port_b_oe_n,
  input  wire logic [2:0]                  port_c_in,
  output logic      [2:0]                  port_c_out,
  output logic      [2:0]                  port_c_oe_n,
  input  wire logic                        cpu_clk_tick,
  input  wire logic                        i2c_enable,
  input  wire logic                        i2c_sda_out,
  input  wire logic                        i2c_scl_out,
  output logic                             i2c_sda_in,
  output logic                             i2c_scl_in,
  input  wire logic [2:0]                  analog_channel_select,
  output logic      [7:0]                  analog_pin_select,
  input  wire logic [3:0]                  ext_int_edge_reg,
  output logic      [3:0]                  ext_int_in,
  input  wire logic                        sci_enable,
  input  wire logic                        sci_tx_out,
  output logic                             sci_rx_in,
  input  wire logic                        usb_tx_active,
  output logic                             low_voltage_detect_off,
  output logic                             osc_12mhz_select
);
  import gpiomc_pkg::*;

  logic [7:0] pa_data_reg;
  logic [7:0] pa_dir_reg;
  logic [7:0] pb_data_reg;
  logic [7:0] pb_dir_reg;
  logic [2:0] pc_data_reg;
  logic [2:0] pc_dir_reg;
  logic       lvd_off_reg;
  logic       osc_sel_reg;
  logic       usb_ind_en_reg;
  logic       clk_out_en_reg;
  logic       clk_out_reg;
  logic [7:0] rdata_next;

  // per bit: output latch when driven, live pin otherwise
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin);
    port_view = (dir & lat) | (~dir & pin);
  endfunction : port_view

  // RL3 latch always written
  // RL4 ports a and b clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pa_data_reg <= RST_PORT_AB;
      pb_data_reg <= RST_PORT_AB;
      pc_data_reg <= RST_PORT_C_LOW;
    end else if (wr_stb) begin
      if (addr == OFS_PORT_A_DATA) begin
        pa_data_reg <= wdata;
      end else if (addr == OFS_PORT_B_DATA) begin
        pb_data_reg <= wdata;
      end else if (addr == OFS_PORT_C_DATA) begin
        // RL5 upper bits dropped
        pc_data_reg <= wdata[PORT_C_PINS-1:0];
      end
    end
  end

  // RL1 software-only direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pa_dir_reg <= RST_PORT_AB;
      pb_dir_reg <= RST_PORT_AB;
      pc_dir_reg <= RST_PORT_C_LOW;
    end else if (wr_stb) begin
      if (addr == OFS_PORT_A_DIR) begin
        pa_dir_reg <= wdata;
      end else if (addr == OFS_PORT_B_DIR) begin
        pb_dir_reg <= wdata;
      end else if (addr == OFS_PORT_C_DIR) begin
        pc_dir_reg <= wdata[PORT_C_PINS-1:0];
      end
    end
  end

  // RL9 misc reset F0h
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvd_off_reg    <= RST_MISC[MISC_LVD_BIT];
      osc_sel_reg    <= RST_MISC[MISC_OSC_BIT];
      usb_ind_en_reg <= RST_MISC[MISC_USB_TX_INDICATOR_ENABLE_BIT];
      clk_out_en_reg <= RST_MISC[MISC_CLKOUT_BIT];
    end else if (wr_stb && addr == OFS_MISC) begin
      // RL10 set only
      lvd_off_reg    <= lvd_off_reg | wdata[MISC_LVD_BIT];
      // RL11 set only
      osc_sel_reg    <= osc_sel_reg | wdata[MISC_OSC_BIT];
      usb_ind_en_reg <= wdata[MISC_USB_TX_INDICATOR_ENABLE_BIT];
      clk_out_en_reg <= wdata[MISC_CLKOUT_BIT];
    end
  end

  // RL2 latch or pin view
  // RL15 fixed reserved bits
  always_comb begin
    rdata_next = 8'h00;
    if (addr == OFS_PORT_A_DATA) begin
      rdata_next = port_view(pa_dir_reg, pa_data_reg, port_a_in);
    end else if (addr == OFS_PORT_A_DIR) begin
      rdata_next = pa_dir_reg;
    end else if (addr == OFS_PORT_B_DATA) begin
      rdata_next = port_view(pb_dir_reg, pb_data_reg, port_b_in);
    end else if (addr == OFS_PORT_B_DIR) begin
      rdata_next = pb_dir_reg;
    end else if (addr == OFS_PORT_C_DATA) begin
      rdata_next = port_view({PORT_C_UNUSED, pc_dir_reg}, {PORT_C_UNUSED, pc_data_reg},
                             {PORT_C_UNUSED, port_c_in});
    end else if (addr == OFS_PORT_C_DIR) begin
      rdata_next = {PORT_C_UNUSED, pc_dir_reg};
    end else if (addr == OFS_MISC) begin
      rdata_next = {MISC_RSVD, lvd_off_reg, osc_sel_reg, usb_ind_en_reg, clk_out_en_reg};
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

  // cpu clock stands in as a toggle on each tick, one cycle late
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_out_reg <= 1'b0;
    end else if (cpu_clk_tick) begin
      clk_out_reg <= ~clk_out_reg;
    end
  end

  // pin drivers; oe_n low drives the pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_out  <= 8'h00;
      port_a_oe_n <= 8'hFF;
      port_b_out  <= 8'h00;
      port_b_oe_n <= 8'hFF;
      port_c_out  <= 3'h0;
      port_c_oe_n <= 3'h7;
    end else begin
      port_a_out  <= pa_data_reg;
      port_a_oe_n <= ~pa_dir_reg;
      port_b_out  <= pb_data_reg;
      port_b_oe_n <= ~pb_dir_reg;
      port_c_out  <= pc_data_reg;
      port_c_oe_n <= ~pc_dir_reg;
      // RL13 clock out on a0
      if (clk_out_en_reg) begin
        port_a_out[0]  <= clk_out_reg;
        port_a_oe_n[0] <= 1'b0;
      end
      // RL6 open drain: only ever drive low
      port_a_out[2:1] <= 2'b00;
      port_a_oe_n[1]  <= ~(pa_dir_reg[1] & ~pa_data_reg[1]);
      port_a_oe_n[2]  <= ~(pa_dir_reg[2] & ~pa_data_reg[2]);
      // RL14 i2c overrides latch
      if (i2c_enable) begin
        port_a_oe_n[1] <= i2c_sda_out;
        port_a_oe_n[2] <= i2c_scl_out;
      end
      // RL14 sci transmit on c1
      if (sci_enable) begin
        port_c_out[1]  <= sci_tx_out;
        port_c_oe_n[1] <= 1'b0;
      end
      // RL12 usb indicator on c2
      if (usb_ind_en_reg) begin
        port_c_out[2]  <= usb_tx_active;
        port_c_oe_n[2] <= 1'b0;
      end
    end
  end

  // peripheral-side inputs, registered to keep outputs on flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      i2c_sda_in        <= 1'b1;
      i2c_scl_in        <= 1'b1;
      sci_rx_in         <= 1'b1;
      analog_pin_select <= 8'h00;
      ext_int_in        <= 4'h0;
    end else begin
      i2c_sda_in <= port_a_in[1];
      i2c_scl_in <= port_a_in[2];
      sci_rx_in  <= port_c_in[0];
      // RL7 one-hot channel
      analog_pin_select <= 8'h01 << analog_channel_select;
      // RL8 enabled input lines only; outputs mask interrupts
      ext_int_in <= ext_int_edge_reg &
                    ~pb_dir_reg[EXT_INT_FIRST_PB +: EXT_INT_LINES] &
                    port_b_in[EXT_INT_FIRST_PB +: EXT_INT_LINES];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_voltage_detect_off <= 1'b0;
      osc_12mhz_select       <= 1'b0;
    end else begin
      low_voltage_detect_off <= lvd_off_reg;
      osc_12mhz_select       <= osc_sel_reg;
    end
  end

  // RL10 sticky detector disable
  lvd_sticky_a: assert property (@(posedge sys_clk) disable iff (rst) // RL10
    $past(lvd_off_reg) |-> lvd_off_reg)
    else $error("detector disable bit cleared without reset");

  // RL11 sticky oscillator select
  osc_sticky_a: assert property (@(posedge sys_clk) disable iff (rst) // RL11
    osc_sel_reg |=> osc_sel_reg)
    else $error("oscillator select cleared without reset");

  // RL3 latch follows write
  latch_write_a: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (wr_stb && addr == OFS_PORT_B_DATA) |=> pb_data_reg == $past(wdata) ##1
    port_b_out == $past(pb_data_reg))
    else $error("port b latch not updated by write");

  // RL2 input read shows pin
  read_view_a: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    (rd_stb && addr == OFS_PORT_A_DATA) |=>
    rdata == (($past(pa_dir_reg) & $past(pa_data_reg)) | (~$past(pa_dir_reg) & $past(port_a_in))))
    else $error("port a read shows wrong view");

  // RL9 misc upper nibble
  misc_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (rd_stb && addr == OFS_MISC) |=> rdata[7:4] == 4'hF)
    else $error("misc reserved bits not ones");

  // RL15 port c upper bits
  pc_rsvd_a: assert property (@(posedge sys_clk) disable iff (rst) // RL15
    (rd_stb && (addr == OFS_PORT_C_DATA || addr == OFS_PORT_C_DIR)) |=> rdata[7:3] == 5'h1F)
    else $error("port c unused bits not ones");

  // RL1 direction drives oe
  dir_oe_a: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    port_b_oe_n == ~$past(pb_dir_reg))
    else $error("port b enable does not follow direction");

  // RL12 usb indicator routed
  usb_route_a: assert property (@(posedge sys_clk) disable iff (rst) // RL12
    usb_ind_en_reg |=> port_c_oe_n[2] == 1'b0 && port_c_out[2] == $past(usb_tx_active))
    else $error("usb indicator not on c2");

  // RL6 never drives high
  open_drain_a: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    port_a_out[2:1] == 2'b00)
    else $error("open drain pin driven high");

  // RL7 channel one-hot
  chan_sel_a: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    !rst |=> analog_pin_select == (8'h01 << $past(analog_channel_select)))
    else $error("analog pin select wrong");
endmodule : gpiomc_top

// ---- pkg/gpiomc_pkg.sv ----
// constants for the gpio ports and misc control block
package gpiomc_pkg;
  localparam int unsigned ADDR_W           = 4;
  localparam logic [3:0]  OFS_PORT_A_DATA  = 4'h0;
  localparam logic [3:0]  OFS_PORT_A_DIR   = 4'h1;
  localparam logic [3:0]  OFS_PORT_B_DATA  = 4'h2;
  localparam logic [3:0]  OFS_PORT_B_DIR   = 4'h3;
  localparam logic [3:0]  OFS_PORT_C_DATA  = 4'h4;
  localparam logic [3:0]  OFS_PORT_C_DIR   = 4'h5;
  localparam logic [3:0]  OFS_MISC         = 4'h9;
  localparam logic [7:0]  RST_PORT_AB      = 8'h00;
  localparam logic [2:0]  RST_PORT_C_LOW   = 3'h0;
  localparam int unsigned PORT_C_PINS      = 3;
  localparam logic [4:0]  PORT_C_UNUSED    = 5'h1F;
  localparam logic [3:0]  MISC_RSVD        = 4'hF;
  localparam logic [7:0]  RST_MISC         = 8'hF0;
  localparam int unsigned MISC_LVD_BIT     = 3;
  localparam int unsigned MISC_OSC_BIT     = 2;
  localparam int unsigned MISC_USB_TX_INDICATOR_ENABLE_BIT   = 1;
  localparam int unsigned MISC_CLKOUT_BIT  = 0;
  localparam int unsigned EXT_INT_LINES    = 4;
  localparam int unsigned EXT_INT_FIRST_PB = 4;
endpackage : gpiomc_pkg
